// [rtl/mmsb_defs.svh]
// Offsets, reset values, field positions and timing counts of the
// two-wire serial bus controller. Definitions only.
// Assumes it is included by its bare name by design and bench.
//
// What this block does
// - Idle bus: both lines released and high.
// - Generate Start/Stop as master; always detect them.
// - First byte: 7-bit address plus direction bit.
// - Bytes are eight bits, MSB first, unlimited.
// - Ninth clock carries acknowledge; master clocks it.
// - Transmitter releases SDA; receiver pulls low.
// - Acknowledge generation switchable; ninth clock kept.
// - Transmit: interrupt, hold SCL until data written.
// - Receive: interrupt, hold SCL until data read.
// - Defer a Start while SDA is low.
// - Lose arbitration on address bit high-versus-low.
// - Inactive means slave, watching for Start.
// - Busy from Start until shortly after Stop.
// - Master ends with Stop or repeated Start.
// - No address acknowledge: master stops, transfer aborted.
// - Master NACKs last byte; slave then releases SDA.
// - 4-bit prescaler sets SCL frequency.
// - Own address register, no reset value.
// - Four modes: master/slave, transmit/receive.
// - Mode field: 00 SR, 01 ST, 10 MR, 11 MT.
// - Write 1 Start, write 0 Stop; read busy.
// - Prescaler input is clock/16 or /512.
// - Pending flag holds SCL low; write 0 clears.
`ifndef MMSB_DEFS_SVH
`define MMSB_DEFS_SVH

// Register byte offsets.
`define MMSB_OFS_CTRL 8'h00
`define MMSB_OFS_STAT 8'h04
`define MMSB_OFS_DATA 8'h08
`define MMSB_OFS_ADDR 8'h0C

// Reset values.
`define MMSB_CTRL_RST 8'h00
`define MMSB_STAT_RST 8'h00
`define MMSB_DATA_RST 8'h00

// Field positions used by the register write decode.
`define MMSB_CTRL_PEND_BIT 4
`define MMSB_STAT_START_BIT 5

// Prescaler input dividers and bus-free delay after a Stop.
`define MMSB_DIV_FAST 10'h010
`define MMSB_DIV_SLOW 10'h200
`define MMSB_BUS_FREE_CYC 3'h4

`endif

// [rtl/mmsb_pkg.sv]
// Types of the two-wire serial bus controller.
// Assumes mmsb_defs.svh is on the include path.
package mmsb_pkg;

    // Operating mode field.
    typedef enum logic [1:0] {
        MMSB_SLV_RX = 2'h0,
        MMSB_SLV_TX = 2'h1,
        MMSB_MST_RX = 2'h2,
        MMSB_MST_TX = 2'h3
    } mmsb_mode_t;

    // Control register layout.
    typedef struct packed {
        logic ack_en;
        logic clk_sel;
        logic irq_en;
        logic pending;
        logic [3:0] prescale;
    } mmsb_ctrl_t;

    // Control/status register layout.
    typedef struct packed {
        mmsb_mode_t mode;
        logic busy;
        logic out_en;
        logic arb_fail;
        logic addr_match;
        logic addr_zero;
        logic last_bit;
    } mmsb_stat_t;

    // Register port request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mmsb_req_t;

    // Open-drain pin drive towards the pads.
    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } mmsb_pins_t;

    // Byte engine states.
    typedef enum logic [2:0] {
        MMSB_IDLE,
        MMSB_START,
        MMSB_XFER,
        MMSB_HOLD,
        MMSB_RSTART,
        MMSB_STOP,
        MMSB_IGNORE
    } mmsb_state_t;

endpackage : mmsb_pkg

// [rtl/mmsb_ctrl.sv]
// Multi-master two-wire serial bus controller, register port and engine.
// Assumes one clock mclk, a pad cell that resolves the open-drain lines
// and a register master that holds its strobes for one cycle.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`include "mmsb_defs.svh"

module mmsb_ctrl (
    // Clock and reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Register port.
    input wire mmsb_pkg::mmsb_req_t req,
    output logic [7:0] rd_data,
    // Interrupt request.
    output logic irq,
    // Bus lines: sensed levels and drive.
    input wire logic scl_i,
    input wire logic sda_i,
    output mmsb_pkg::mmsb_pins_t pins
);
    import mmsb_pkg::*;

    mmsb_ctrl_t ctrl_r;
    mmsb_stat_t stat_r;
    mmsb_state_t state_r;
    logic [7:0] shift_r;
    logic [7:0] own_addr_r;
    logic [3:0] bit_cnt_r;
    logic [1:0] step_r;
    logic addr_ph_r;
    logic master_r;
    logic start_req_r;
    logic stop_req_r;
    logic scl_low_r;
    logic sda_low_r;
    logic busy_r;
    logic [2:0] free_cnt_r;
    logic [9:0] pre_cnt_r;
    logic [3:0] div_cnt_r;
    logic tick_r;
    logic [7:0] rd_data_r;
    logic irq_r;
    logic [2:0] scl_sy_r;
    logic [2:0] sda_sy_r;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_data;
    logic wr_addr;
    logic rd_dsr;
    logic tx_now;
    logic addr_hit;

    // True when the device drives data in the current byte.
    function automatic logic is_tx(input logic addr_ph,
                                   input logic master,
                                   input mmsb_mode_t mode);
        if (addr_ph) begin
            is_tx = master;
        end else begin
            is_tx = (mode == MMSB_MST_TX) || (mode == MMSB_SLV_TX);
        end
    endfunction : is_tx

    // Two flops before any logic; the third keeps the previous level.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scl_sy_r <= 3'h7;
            sda_sy_r <= 3'h7;
        end else begin
            scl_sy_r <= {scl_sy_r[1:0], scl_i};
            sda_sy_r <= {sda_sy_r[1:0], sda_i};
        end
    end

    // Bus events seen on the synchronised lines, never on the first flop.
    assign scl_s = scl_sy_r[1];
    assign sda_s = sda_sy_r[1];
    assign scl_rise = scl_s && !scl_sy_r[2];
    assign scl_fall = !scl_s && scl_sy_r[2];
    assign start_det = scl_s && scl_sy_r[2] && sda_sy_r[2] && !sda_s;
    assign stop_det = scl_s && scl_sy_r[2] && !sda_sy_r[2] && sda_s;

    // Register decode; the master never issues both strobes together.
    assign wr_ctrl = req.wr && (req.addr == `MMSB_OFS_CTRL);
    assign wr_stat = req.wr && (req.addr == `MMSB_OFS_STAT);
    assign wr_data = req.wr && (req.addr == `MMSB_OFS_DATA);
    assign wr_addr = req.wr && (req.addr == `MMSB_OFS_ADDR);
    assign rd_dsr = req.rd && (req.addr == `MMSB_OFS_DATA);
    assign tx_now = is_tx(addr_ph_r, master_r, stat_r.mode);
    assign addr_hit = (shift_r[7:1] == own_addr_r[7:1]) || (shift_r == 8'h00);

    // Prescaler: clock/16 or /512, then divided by prescale plus one.
    // A tick marks one half period of the generated clock.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pre_cnt_r <= 10'h000;
            div_cnt_r <= 4'h0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (pre_cnt_r == ((ctrl_r.clk_sel ? `MMSB_DIV_SLOW
                               : `MMSB_DIV_FAST) - 10'h001)) begin
                pre_cnt_r <= 10'h000;
                if (div_cnt_r >= ctrl_r.prescale) begin
                    div_cnt_r <= 4'h0;
                    tick_r <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 4'h1;
                end
            end else begin
                pre_cnt_r <= pre_cnt_r + 10'h001;
            end
        end
    end

    // Busy from any Start; free a few clocks after a Stop.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r <= 1'b0;
            free_cnt_r <= 3'h0;
        end else if (start_det) begin
            busy_r <= 1'b1;
            free_cnt_r <= 3'h0;
        end else if (stop_det) begin
            free_cnt_r <= `MMSB_BUS_FREE_CYC;
        end else if (free_cnt_r != 3'h0) begin
            free_cnt_r <= free_cnt_r - 3'h1;
            if (free_cnt_r == 3'h1) begin
                busy_r <= 1'b0;
            end
        end
    end

    // The own address keeps no reset value, so software must load it.
    always_ff @(posedge mclk) begin
        if (wr_addr) begin
            own_addr_r <= req.wdata;
        end
    end

    // Software writes first, engine updates after them, so a hardware
    // set of the pending flag wins over a clear in the same cycle.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= `MMSB_CTRL_RST;
            stat_r <= `MMSB_STAT_RST;
            shift_r <= `MMSB_DATA_RST;
            state_r <= MMSB_IDLE;
            bit_cnt_r <= 4'h0;
            step_r <= 2'h0;
            addr_ph_r <= 1'b0;
            master_r <= 1'b0;
            start_req_r <= 1'b0;
            stop_req_r <= 1'b0;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r.ack_en <= req.wdata[7];
                ctrl_r.clk_sel <= req.wdata[6];
                ctrl_r.irq_en <= req.wdata[5];
                ctrl_r.prescale <= req.wdata[3:0];
                if (!req.wdata[`MMSB_CTRL_PEND_BIT]) begin
                    ctrl_r.pending <= 1'b0;
                end
            end
            if (wr_stat) begin
                stat_r.mode <= mmsb_mode_t'(req.wdata[7:6]);
                stat_r.out_en <= req.wdata[4];
                stat_r.arb_fail <= 1'b0;
                if (req.wdata[`MMSB_STAT_START_BIT]) begin
                    start_req_r <= 1'b1;
                    stop_req_r <= 1'b0;
                end else if (master_r) begin
                    stop_req_r <= 1'b1;
                end
            end
            // A data write in transmit or a data read in receive
            // also lets the held clock go.
            if (wr_data) begin
                shift_r <= req.wdata;
                if (tx_now && state_r == MMSB_HOLD) begin
                    ctrl_r.pending <= 1'b0;
                end
            end
            if (rd_dsr && !tx_now && state_r == MMSB_HOLD) begin
                ctrl_r.pending <= 1'b0;
            end
            if (start_det || stop_det) begin
                stat_r.addr_match <= 1'b0;
                stat_r.addr_zero <= 1'b0;
            end

            if (!stat_r.out_en) begin
                // Disabled: release both lines and sit as a slave.
                state_r <= MMSB_IDLE;
                master_r <= 1'b0;
                scl_low_r <= 1'b0;
                sda_low_r <= 1'b0;
            end else begin
                unique case (state_r)
                    MMSB_IDLE: begin
                        scl_low_r <= 1'b0;
                        sda_low_r <= 1'b0;
                        if (start_det) begin
                            state_r <= MMSB_XFER;
                            addr_ph_r <= 1'b1;
                            bit_cnt_r <= 4'h0;
                        end else if (start_req_r && stat_r.mode[1] &&
                                     !busy_r && sda_s && scl_s) begin
                            // A low SDA from another master defers us.
                            state_r <= MMSB_START;
                            step_r <= 2'h0;
                        end
                    end
                    MMSB_RSTART: begin
                        // Release SDA with SCL low, then let SCL rise.
                        sda_low_r <= 1'b0;
                        if (step_r == 2'h0 && tick_r) begin
                            scl_low_r <= 1'b0;
                            step_r <= 2'h1;
                        end else if (step_r == 2'h1 && tick_r && scl_s) begin
                            state_r <= MMSB_START;
                            step_r <= 2'h0;
                        end
                    end
                    MMSB_START: begin
                        if (step_r == 2'h0 && tick_r) begin
                            sda_low_r <= 1'b1;
                            step_r <= 2'h1;
                        end else if (step_r == 2'h1 && tick_r) begin
                            // The written byte goes out as the address.
                            scl_low_r <= 1'b1;
                            sda_low_r <= !shift_r[7];
                            state_r <= MMSB_XFER;
                            addr_ph_r <= 1'b1;
                            bit_cnt_r <= 4'h0;
                            master_r <= 1'b1;
                            start_req_r <= 1'b0;
                        end
                    end
                    MMSB_XFER: begin
                        // Master clock: the fall waits for the line high, so a
                        // slave stretching SCL slows us down.
                        if (master_r && tick_r) begin
                            if (scl_low_r) begin
                                scl_low_r <= 1'b0;
                            end else if (scl_s) begin
                                scl_low_r <= 1'b1;
                            end
                        end
                        if (scl_rise) begin
                            if (bit_cnt_r < 4'h8) begin
                                shift_r <= {shift_r[6:0], sda_s};
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                                if (master_r && addr_ph_r &&
                                    !sda_low_r && !sda_s) begin
                                    // Another master pulled low: back off.
                                    master_r <= 1'b0;
                                    stat_r.arb_fail <= 1'b1;
                                    stat_r.mode <= MMSB_SLV_RX;
                                    scl_low_r <= 1'b0;
                                    ctrl_r.pending <= 1'b1;
                                end
                            end else begin
                                stat_r.last_bit <= sda_s;
                            end
                        end
                        if (scl_fall) begin
                            if (bit_cnt_r == 4'h8) begin
                                bit_cnt_r <= 4'h9;
                                if (tx_now) begin
                                    sda_low_r <= 1'b0;
                                end else if (addr_ph_r) begin
                                    sda_low_r <= addr_hit && ctrl_r.ack_en;
                                    stat_r.addr_match <= addr_hit;
                                    stat_r.addr_zero <= (shift_r == 8'h00);
                                    if (addr_hit) begin
                                        stat_r.mode <= shift_r[0] ?
                                            MMSB_SLV_TX : MMSB_SLV_RX;
                                    end
                                end else begin
                                    sda_low_r <= ctrl_r.ack_en;
                                end
                            end else if (bit_cnt_r == 4'h9) begin
                                bit_cnt_r <= 4'h0;
                                addr_ph_r <= 1'b0;
                                sda_low_r <= 1'b0;
                                if (!master_r && addr_ph_r &&
                                    !stat_r.addr_match) begin
                                    state_r <= MMSB_IGNORE;
                                end else if (!master_r && !addr_ph_r &&
                                             stat_r.mode == MMSB_SLV_TX &&
                                             stat_r.last_bit) begin
                                    // Master refused: release for its Stop.
                                    state_r <= MMSB_IGNORE;
                                end else begin
                                    state_r <= MMSB_HOLD;
                                    scl_low_r <= 1'b1;
                                    ctrl_r.pending <= 1'b1;
                                end
                            end else begin
                                sda_low_r <= tx_now && !shift_r[7];
                            end
                        end
                        if (!master_r && start_det) begin
                            addr_ph_r <= 1'b1;
                            bit_cnt_r <= 4'h0;
                            sda_low_r <= 1'b0;
                        end else if (!master_r && stop_det) begin
                            state_r <= MMSB_IDLE;
                        end
                    end
                    MMSB_HOLD: begin
                        scl_low_r <= 1'b1;
                        if (!master_r && stop_det) begin
                            state_r <= MMSB_IDLE;
                        end else if (!ctrl_r.pending) begin
                            if (master_r && stop_req_r) begin
                                // Also the way out after a refused address.
                                state_r <= MMSB_STOP;
                                step_r <= 2'h0;
                                sda_low_r <= 1'b1;
                            end else if (master_r && start_req_r) begin
                                state_r <= MMSB_RSTART;
                                step_r <= 2'h0;
                            end else begin
                                state_r <= MMSB_XFER;
                                scl_low_r <= master_r;
                                sda_low_r <= tx_now && !shift_r[7];
                            end
                        end
                    end
                    MMSB_STOP: begin
                        if (step_r == 2'h0 && tick_r) begin
                            scl_low_r <= 1'b0;
                            step_r <= 2'h1;
                        end else if (step_r == 2'h1 && tick_r && scl_s) begin
                            sda_low_r <= 1'b0;
                            state_r <= MMSB_IDLE;
                            master_r <= 1'b0;
                            stop_req_r <= 1'b0;
                            stat_r.mode <= MMSB_SLV_RX;
                        end
                    end
                    MMSB_IGNORE: begin
                        scl_low_r <= 1'b0;
                        sda_low_r <= 1'b0;
                        if (start_det) begin
                            state_r <= MMSB_XFER;
                            addr_ph_r <= 1'b1;
                            bit_cnt_r <= 4'h0;
                        end else if (stop_det) begin
                            state_r <= MMSB_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Read data stands in the cycle after the strobe; unmapped reads 0.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_r <= 8'h00;
        end else if (req.rd) begin
            unique case (req.addr)
                `MMSB_OFS_CTRL: rd_data_r <= ctrl_r;
                `MMSB_OFS_STAT: rd_data_r <= {stat_r.mode, busy_r,
                                              stat_r[4:0]};
                `MMSB_OFS_DATA: rd_data_r <= shift_r;
                `MMSB_OFS_ADDR: rd_data_r <= own_addr_r;
                default: rd_data_r <= 8'h00;
            endcase
        end else begin
            rd_data_r <= 8'h00;
        end
    end

    // Interrupt is the pending flag gated by its enable.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= ctrl_r.pending && ctrl_r.irq_en;
        end
    end

    assign rd_data = rd_data_r;
    assign irq = irq_r;
    // Open drain: the level is always low, the enables pull the line.
    assign pins = '{scl_o: 1'b0, scl_oe: scl_low_r,
                    sda_o: 1'b0, sda_oe: sda_low_r};

endmodule : mmsb_ctrl

// [sim/mmsb_ctrl_sva.sv]
// Port assertions for the two-wire bus controller.
// Assumes pull-ups on both lines and a bind from the bench.
module mmsb_ctrl_sva (
    // Clock, reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Registers.
    input wire mmsb_pkg::mmsb_req_t req,
    input wire logic [7:0] rd_data,
    input wire logic irq,
    // Lines.
    input wire logic scl_i,
    input wire logic sda_i,
    input wire mmsb_pkg::mmsb_pins_t pins
);
    import mmsb_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Open drain: a pad may only pull low, never drive high.
    property p_od; !pins.scl_o && !pins.sda_o; endproperty
    property p_rst; $rose(arst_n) |-> !pins.scl_oe && !pins.sda_oe;
    endproperty
    property p_rd; !$past(req.rd) |-> rd_data == 8'h00; endproperty
    property p_hold;
        irq && $past(irq) && !$past(req.wr) && !$past(req.rd) |-> pins.scl_oe;
    endproperty
    property p_rise; $rose(irq) |-> ##[0:2] pins.scl_oe; endproperty
    // Only software service may take the interrupt away.
    property p_fall;
        $fell(irq) |-> $past(req.wr, 2) || $past(req.rd, 2)
            || $past(req.wr, 3) || $past(req.rd, 3);
    endproperty
    property p_defer; (scl_i && !sda_i) [*3] |-> !$rose(pins.sda_oe);
    endproperty
    property p_dclr; irq && req.wr && req.addr == 8'h08 |-> ##[1:3] !irq;
    endproperty
    property p_pclr;
        irq && req.wr && req.addr == 8'h00 && !req.wdata[4] |-> ##[1:3] !irq;
    endproperty
    a_od: assert property (p_od)
        else $error("pad drives a line high");
    a_rst: assert property (p_rst)
        else $error("line pulled right after reset");
    a_rd: assert property (p_rd)
        else $error("read data outside read cycle");
    a_hold: assert property (p_hold)
        else $error("clock released while pending");
    a_rise: assert property (p_rise)
        else $error("interrupt without clock hold");
    a_fall: assert property (p_fall)
        else $error("interrupt dropped without access");
    a_defer: assert property (p_defer)
        else $error("start while data line low");
    a_dclr: assert property (p_dclr)
        else $error("data write left interrupt");
    a_pclr: assert property (p_pclr)
        else $error("pending clear ignored");
    c_irq: cover property ($rose(irq));
    c_stop: cover property ($fell(pins.sda_oe) && scl_i);
    c_defer: cover property ((scl_i && !sda_i) [*3]);
endmodule : mmsb_ctrl_sva

// [sim/mmsb_slave_model.sv]
// Slave on the far side of the lines: takes bytes, acknowledges each.
// Assumes resolved line levels and the controller's clock.
module mmsb_slave_model (
    // Clock, reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Lines.
    input wire logic scl,
    input wire logic sda,
    output logic ack_oe,
    // Observations.
    output logic [7:0] got,
    output logic [3:0] n_stop
);
    logic scl_q, sda_q;
    logic [3:0] bit_n;
    logic [7:0] sr;
    // Edge tracking; the model never stretches the clock, so it is fast.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            {scl_q, sda_q, ack_oe, bit_n, n_stop} <= 11'h600;
            got <= 8'h00;
            sr <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl && scl_q && sda_q && !sda) begin
                bit_n <= 4'h0;
            end else if (scl && scl_q && !sda_q && sda) begin
                n_stop <= n_stop + 4'h1;
            end else if (scl && !scl_q) begin
                sr <= {sr[6:0], sda};
                bit_n <= bit_n + 4'h1;
            end else if (!scl && scl_q && bit_n == 4'h8) begin
                ack_oe <= 1'b1;
                got <= sr;
            end else if (!scl && scl_q && bit_n == 4'h9) begin
                ack_oe <= 1'b0;
                bit_n <= 4'h0;
            end
        end
    end
endmodule : mmsb_slave_model

// [sim/multi_master_serial_bus_ctrl_bench.sv]
// Bench: register tasks, a slave on the lines, random bytes.
// Assumes pull-ups on both lines and the defs header on the path.
`include "mmsb_defs.svh"
module multi_master_serial_bus_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import mmsb_pkg::*;
    logic mclk, arst_n, hog, irq, ack_oe;
    logic [7:0] rd_data, got, v, b;
    logic [3:0] n_stop;
    mmsb_req_t req;
    mmsb_pins_t pins;
    wire logic scl, sda;
    int n_fail, n_compared, cyc, i;
    // Wired-and lines: low while any party pulls.
    assign scl = !pins.scl_oe;
    assign sda = !(pins.sda_oe || ack_oe || hog);
    mmsb_ctrl dut_u (.mclk(mclk), .arst_n(arst_n), .req(req),
        .rd_data(rd_data), .irq(irq), .scl_i(scl), .sda_i(sda),
        .pins(pins));
    mmsb_slave_model slv_u (.mclk(mclk), .arst_n(arst_n), .scl(scl),
        .sda(sda), .ack_oe(ack_oe), .got(got), .n_stop(n_stop));
    // 25 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // A spare edge between accesses keeps a strobe from two writes at once.
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge mclk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        @(negedge mclk);
        v = rd_data;
    endtask : acc
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        check(v, exp);
    endtask : rd_chk
    task automatic wait_irq;
        for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge mclk);
        @(negedge mclk);
    endtask : wait_irq
    function automatic logic [7:0] stat_exp(input mmsb_mode_t m,
        input logic busy);
        return {m, busy, 1'b1, 4'h0};
    endfunction : stat_exp
    task automatic summarize;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    // Cycle ceiling well above the roughly 3000 cycles the run needs.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        arst_n = 1'b0;
        hog = 1'b0;
        req = '0;
        cyc = 0;
        n_fail = 0;
        n_compared = 0;
        void'($urandom(32'hC35FBD39));
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        rd_chk(`MMSB_OFS_CTRL, 8'h00);
        rd_chk(`MMSB_OFS_STAT, 8'h00);
        rd_chk(8'h10, 8'h00);
        acc(1'b1, `MMSB_OFS_ADDR, 8'h5A);
        acc(1'b1, `MMSB_OFS_CTRL, 8'hA2);
        acc(1'b1, `MMSB_OFS_STAT, 8'h10);
        rd_chk(`MMSB_OFS_CTRL, 8'hA2);
        // Address byte with write direction, then two random data bytes.
        for (i = 0; i < 3; i++) begin
            b = (i == 0) ? {7'($urandom), 1'b0} : 8'($urandom);
            acc(1'b1, `MMSB_OFS_DATA, b);
            if (i == 0) acc(1'b1, `MMSB_OFS_STAT, 8'hF0);
            else acc(1'b1, `MMSB_OFS_CTRL, 8'hA2);
            check({7'h00, irq}, 8'h00);
            wait_irq();
            check({7'h00, irq}, 8'h01);
            check(got, b);
            check({7'h00, pins.scl_oe}, 8'h01);
            rd_chk(`MMSB_OFS_STAT, stat_exp(MMSB_MST_TX, 1'b1));
        end
        acc(1'b1, `MMSB_OFS_STAT, 8'hD0);
        acc(1'b1, `MMSB_OFS_CTRL, 8'hA2);
        for (i = 0; i < 2000 && n_stop !== 4'h1; i++) @(posedge mclk);
        repeat (16) @(posedge mclk);
        check({4'h0, n_stop}, 8'h01);
        rd_chk(`MMSB_OFS_STAT, stat_exp(MMSB_SLV_RX, 1'b0));
        acc(1'b1, `MMSB_OFS_CTRL, 8'hB2);
        rd_chk(`MMSB_OFS_CTRL, 8'hA2);
        // Another master holds the data line low; our Start must wait.
        @(posedge mclk);
        hog <= 1'b1;
        acc(1'b1, `MMSB_OFS_STAT, 8'hF0);
        repeat (200) @(posedge mclk);
        check({6'h00, pins.scl_oe, pins.sda_oe}, 8'h00);
        summarize();
    end
endmodule : multi_master_serial_bus_ctrl_bench
bind mmsb_ctrl mmsb_ctrl_sva chk_u (.mclk(mclk), .arst_n(arst_n),
    .req(req), .rd_data(rd_data), .irq(irq), .scl_i(scl_i),
    .sda_i(sda_i), .pins(pins));
